// file: wrcl_pkg.sv
// Constants, field layout and timing counts of the wiper register command
// logic. Assumes a 100 MHz core clock and a two-wire master on the link.
// Functional notes
// (RQ1) Exactly one of 1024 tap select lines is active, decoded from wiper; reset clears all of them until the recall.
// (RQ2) Write-wiper instruction loads the wiper register with host data.
// (RQ3) Transfer instruction copies a selected setting register into wiper.
// (RQ4) After power-up, setting register zero is copied into the wiper.
// (RQ5) Wiper register is volatile; only the power-up recall restores it.
// (RQ6) Four 10-bit retained setting registers, host readable and writable.
// (RQ7) Every setting register change is a retained write, within 10 ms.
// (RQ8) Bits 9 to 0 hold position 0 to 1023, bit 9 most significant.
// (RQ9) Wiper and setting read/write are four bytes: id, instruction, data.
// (RQ10) Both transfer instructions are two bytes: id and instruction only.
// (RQ11) Setting-to-wiper is volatile; taps follow after the response delay.
// (RQ12) Wiper-to-setting is a retained write lasting the write time.
// (RQ13) Wiper read: opcode 100, returns pad plus bits 9:8, then bits 7:0.
// (RQ14) Wiper write: opcode 101, bits 9:8 then 7:0, each byte acknowledged.
// (RQ15) Setting read: opcode 101 with read bit, same two-byte data layout.
// (RQ16) Select bits 00, 01, 10, 11 choose setting register zero to three.
// (RQ17) Command continues only if id address bits match the strap inputs.
// (RQ18) During a retained write the id byte is not acknowledged.
// (RQ19) Setting-to-wiper opcode 110 read; wiper-to-setting 111 write.
// (RQ20) Instructions are ignored until the retained write has finished.
// (RQ21) Upper six pad bits are dropped on write, driven fixed on read.
package wrcl_pkg;
   localparam int          POS_W          = 10;
   localparam int          TAPS           = 1024;
   localparam int          NUM_SET        = 4;
   localparam logic [3:0]  DEVICE_TYPE_DEFAULT = 4'hA; // Arbitrary value.
   localparam int          ID_TYPE_LSB    = 4;
   localparam int          ID_ZERO_BIT    = 3;
   localparam int          ID_STRAP_HI    = 2;
   localparam int          ID_STRAP_LO    = 1;
   localparam int          ID_RW_BIT      = 0;
   localparam int          INS_OP_LSB     = 5;
   localparam int          INS_SEL_LSB    = 2;
   localparam logic [2:0]  OP_RD_WIPER    = 3'h4;
   localparam logic [2:0]  OP_WR_WIPER    = 3'h5;
   localparam logic [2:0]  OP_RD_SET      = 3'h5;
   localparam logic [2:0]  OP_WR_SET      = 3'h6;
   localparam logic [2:0]  OP_TO_WIPER    = 3'h6;
   localparam logic [2:0]  OP_TO_SET      = 3'h7;
   localparam logic [5:0]  PAD_FILL       = 6'h00;
   localparam logic [9:0]  WIPER_RESET    = 10'h000;
   localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
   localparam logic [1:0]  BYTE_HI        = 2'h2;
   localparam logic [1:0]  BYTE_LO        = 2'h3;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          NV_WRITE_MAX_NS = 10_000_000;
   localparam int          NV_WRITE_CYCLES = NV_WRITE_MAX_NS / CLK_PERIOD_NS;
   localparam int          WIPER_DELAY_MAX_NS = 100;
   localparam int          WIPER_DELAY_CYCLES =
      WIPER_DELAY_MAX_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX} wrcl_phase_e;
   typedef enum logic [2:0] {
      CMD_NONE, CMD_RD_WIPER, CMD_WR_WIPER, CMD_RD_SET,
      CMD_WR_SET, CMD_TO_WIPER, CMD_TO_SET
   } wrcl_cmd_e;
endpackage

// file: wrcl_top.sv
// Two-wire slave command logic of a 1024-tap digital potentiometer.
// Assumes the master clocks the link far below the core clock, so every
// link edge is seen after the three-stage pin samplers.
`timescale 1ns/100ps
module wrcl_top #(
   parameter int         P_NV_WRITE_CYCLES    = wrcl_pkg::NV_WRITE_CYCLES,
   parameter int         P_WIPER_DELAY_CYCLES = wrcl_pkg::WIPER_DELAY_CYCLES,
   parameter logic [3:0] P_DEVICE_TYPE        = wrcl_pkg::DEVICE_TYPE_DEFAULT
) (
   input  wire logic          i_clk,
   input  wire logic          i_rstn,
   input  wire logic          i_scl,
   input  wire logic          i_sda_in,
   input  wire logic          i_addr_strap_high,
   input  wire logic          i_addr_strap_low,
   output logic               o_sda_out,
   output logic               o_sda_oen,
   output logic [9:0]         o_wiper_position,
   output logic [1023:0]      o_tap_sel,
   output logic               o_nv_busy
);
   localparam int NVW = $clog2(P_NV_WRITE_CYCLES + 1);
   localparam int DLW = $clog2(P_WIPER_DELAY_CYCLES + 1);

   function automatic logic [1023:0] tap_decode(input logic [9:0] pos);
      tap_decode = '0;
      tap_decode[pos] = 1'b1;
   endfunction

   // Pin samplers: stage 0 feeds stage 1 only; a level counts once 1 and 2
   // agree.
   logic [3:0]                 pin_raw;
   logic [2:0]                 sync_ff [4];
   logic [3:0]                 pin_agree;
   logic [3:0]                 pin_val;
   assign pin_raw = {i_scl, i_sda_in, i_addr_strap_high, i_addr_strap_low};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               sync_ff[g] <= 3'h7;
            end else begin
               sync_ff[g] <= {sync_ff[g][1:0], pin_raw[g]};
            end
         end
         assign pin_agree[g] = sync_ff[g][1] == sync_ff[g][2];
         assign pin_val[g]   = sync_ff[g][2];
      end
   endgenerate

   logic                       scl_ff;
   logic                       sda_ff;
   logic [1:0]                 strap_ff;
   wire                        scl_rise = pin_agree[3] & pin_val[3] & ~scl_ff;
   wire                        scl_fall = pin_agree[3] & ~pin_val[3] & scl_ff;
   wire                        sda_rise = pin_agree[2] & pin_val[2] & ~sda_ff;
   wire                        sda_fall = pin_agree[2] & ~pin_val[2] & sda_ff;
   wire                        start_det = sda_fall & scl_ff;
   wire                        stop_det  = sda_rise & scl_ff;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_ff   <= 1'b1;
         sda_ff   <= 1'b1;
         strap_ff <= 2'h0;
      end else begin
         if (pin_agree[3]) scl_ff <= pin_val[3];
         if (pin_agree[2]) sda_ff <= pin_val[2];
         if (pin_agree[1]) strap_ff[1] <= pin_val[1];
         if (pin_agree[0]) strap_ff[0] <= pin_val[0];
      end
   end

   // Protocol state.
   wrcl_pkg::wrcl_phase_e      ph_ff;
   wrcl_pkg::wrcl_cmd_e        cmd_ff;
   logic [3:0]                 bit_ff;
   logic [1:0]                 byte_ff;
   logic [7:0]                 sh_ff;
   logic                       rw_ff;
   logic [1:0]                 sel_ff;
   logic [1:0]                 hi_ff;
   logic [9:0]                 dat_ff;
   logic                       pend_ff;
   logic                       mack_ff;
   logic                       drive_ff;
   logic                       recall_ff;
   logic [NVW-1:0]             nv_cnt_ff;
   logic [DLW-1:0]             dly_ff;
   logic [9:0]                 wiper_ff;
   logic [1023:0]              tap_ff;
   logic [9:0]                 set_mem [wrcl_pkg::NUM_SET];

   wire                        nv_busy = nv_cnt_ff != '0;
   wire                        byte_done = bit_ff == wrcl_pkg::BITS_PER_BYTE;

   // Identification byte check.
   wire                        id_ok =
      sh_ff[7:wrcl_pkg::ID_TYPE_LSB] == P_DEVICE_TYPE &&
      !sh_ff[wrcl_pkg::ID_ZERO_BIT] &&
      sh_ff[wrcl_pkg::ID_STRAP_HI] == strap_ff[1] &&     // RQ17
      sh_ff[wrcl_pkg::ID_STRAP_LO] == strap_ff[0] &&     // RQ17
      !nv_busy && !recall_ff;                            // RQ18 RQ20

   // Instruction decode; the read bit tells apart the shared opcodes.
   wire [2:0]                  ins_op  = sh_ff[7:wrcl_pkg::INS_OP_LSB];
   wire [1:0]                  ins_sel = sh_ff[wrcl_pkg::INS_SEL_LSB +: 2];
   wrcl_pkg::wrcl_cmd_e        ins_cmd;
   assign ins_cmd =
      (rw_ff && ins_op == wrcl_pkg::OP_RD_WIPER) ? wrcl_pkg::CMD_RD_WIPER :
      (!rw_ff && ins_op == wrcl_pkg::OP_WR_WIPER) ? wrcl_pkg::CMD_WR_WIPER :
      (rw_ff && ins_op == wrcl_pkg::OP_RD_SET) ? wrcl_pkg::CMD_RD_SET :
      (!rw_ff && ins_op == wrcl_pkg::OP_WR_SET) ? wrcl_pkg::CMD_WR_SET :
      (rw_ff && ins_op == wrcl_pkg::OP_TO_WIPER) ? wrcl_pkg::CMD_TO_WIPER :
      (!rw_ff && ins_op == wrcl_pkg::OP_TO_SET) ? wrcl_pkg::CMD_TO_SET :
      wrcl_pkg::CMD_NONE;                                // RQ13 RQ14 RQ15 RQ19
   wire                        ins_short =
      ins_cmd == wrcl_pkg::CMD_TO_WIPER || ins_cmd == wrcl_pkg::CMD_TO_SET;
   wire                        cmd_rd =
      cmd_ff == wrcl_pkg::CMD_RD_WIPER || cmd_ff == wrcl_pkg::CMD_RD_SET;
   wire                        cmd_wr =
      cmd_ff == wrcl_pkg::CMD_WR_WIPER || cmd_ff == wrcl_pkg::CMD_WR_SET;

   // Read data in the two-byte layout with fixed pad bits.
   wire [9:0]                  rd_val = (cmd_ff == wrcl_pkg::CMD_RD_WIPER) ?
                                        wiper_ff : set_mem[sel_ff]; // RQ16
   wire [7:0]                  tx_byte = (byte_ff == wrcl_pkg::BYTE_HI) ?
      {wrcl_pkg::PAD_FILL, rd_val[9:8]} : rd_val[7:0]; // RQ13 RQ15 RQ21

   // Byte accepted or refused at the falling edge closing its eighth bit.
   logic                       byte_ack;
   always_comb begin
      case (byte_ff)
         2'h0:    byte_ack = id_ok;
         2'h1:    byte_ack = ins_cmd != wrcl_pkg::CMD_NONE;
         default: byte_ack = cmd_wr;                     // RQ9
      endcase
   end

   wire                        exec = stop_det & pend_ff;
   wire                        ack_to_rx = byte_ff == 2'h1 ||
      (cmd_wr && byte_ff != 2'h0);                       // RQ9 RQ10
   wire                        ack_to_tx = cmd_rd && byte_ff == 2'h2;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ph_ff    <= wrcl_pkg::PH_IDLE;
         cmd_ff   <= wrcl_pkg::CMD_NONE;
         bit_ff   <= 4'h0;
         byte_ff  <= 2'h0;
         sh_ff    <= 8'h00;
         rw_ff    <= 1'b0;
         sel_ff   <= 2'h0;
         hi_ff    <= 2'h0;
         dat_ff   <= 10'h000;
         pend_ff  <= 1'b0;
         mack_ff  <= 1'b0;
         drive_ff <= 1'b0;
      end else if (start_det) begin
         ph_ff    <= wrcl_pkg::PH_RX;
         cmd_ff   <= wrcl_pkg::CMD_NONE;
         bit_ff   <= 4'h0;
         byte_ff  <= 2'h0;
         pend_ff  <= 1'b0;
         drive_ff <= 1'b0;
      end else if (stop_det) begin
         ph_ff    <= wrcl_pkg::PH_IDLE;
         pend_ff  <= 1'b0;
         drive_ff <= 1'b0;
      end else if (scl_rise) begin
         if (ph_ff == wrcl_pkg::PH_RX && !byte_done) begin
            sh_ff  <= {sh_ff[6:0], sda_ff};
            bit_ff <= bit_ff + 4'h1;
         end
         // The master answers on the ninth clock. Sampling on the eighth
         // would read back our own last data bit instead.
         if (ph_ff == wrcl_pkg::PH_TX &&
             bit_ff == wrcl_pkg::BITS_PER_BYTE + 4'h1) begin
            mack_ff <= ~sda_ff;
         end
      end else if (scl_fall) begin
         case (ph_ff)
            wrcl_pkg::PH_RX: begin
               if (byte_done) begin
                  if (byte_ack) begin
                     ph_ff    <= wrcl_pkg::PH_ACK;
                     drive_ff <= 1'b1;
                     byte_ff  <= byte_ff + 2'h1;
                  end else begin
                     ph_ff <= wrcl_pkg::PH_IDLE;
                  end
                  case (byte_ff)
                     2'h0: rw_ff <= sh_ff[wrcl_pkg::ID_RW_BIT];
                     2'h1: begin
                        cmd_ff  <= ins_cmd;
                        sel_ff  <= ins_sel;
                        pend_ff <= ins_short;            // RQ10
                     end
                     2'h2: hi_ff <= sh_ff[1:0];          // RQ14 RQ21
                     default: begin
                        dat_ff  <= {hi_ff, sh_ff};       // RQ8 RQ14
                        pend_ff <= 1'b1;
                     end
                  endcase
               end
            end
            wrcl_pkg::PH_ACK: begin
               bit_ff <= 4'h0;
               if (ack_to_tx) begin
                  ph_ff    <= wrcl_pkg::PH_TX;
                  sh_ff    <= {tx_byte[6:0], 1'b0};
                  drive_ff <= ~tx_byte[7];
                  bit_ff   <= 4'h1;
                  byte_ff  <= byte_ff + 2'h1;
               end else if (ack_to_rx) begin
                  ph_ff    <= wrcl_pkg::PH_RX;
                  drive_ff <= 1'b0;
               end else begin
                  ph_ff    <= wrcl_pkg::PH_IDLE;
                  drive_ff <= 1'b0;
               end
            end
            wrcl_pkg::PH_TX: begin
               if (bit_ff == wrcl_pkg::BITS_PER_BYTE + 4'h1) begin
                  // Master acknowledge clock just ended.
                  if (mack_ff && byte_ff == wrcl_pkg::BYTE_LO) begin
                     sh_ff    <= {tx_byte[6:0], 1'b0};
                     drive_ff <= ~tx_byte[7];
                     bit_ff   <= 4'h1;
                     byte_ff  <= byte_ff + 2'h1;
                  end else begin
                     ph_ff    <= wrcl_pkg::PH_IDLE;
                     drive_ff <= 1'b0;
                  end
               end else if (byte_done) begin
                  drive_ff <= 1'b0;
                  bit_ff   <= bit_ff + 4'h1;
               end else begin
                  drive_ff <= ~sh_ff[7];
                  sh_ff    <= {sh_ff[6:0], 1'b0};
                  bit_ff   <= bit_ff + 4'h1;
               end
            end
            default: drive_ff <= 1'b0;
         endcase
      end
   end

   // Retained setting registers keep their value through reset, which
   // stands for power cycling; the write timer starts when one changes.
   wire                        set_wr = exec &&
      (cmd_ff == wrcl_pkg::CMD_WR_SET || cmd_ff == wrcl_pkg::CMD_TO_SET);
   wire [9:0]                  set_wdata =
      (cmd_ff == wrcl_pkg::CMD_TO_SET) ? wiper_ff : dat_ff; // RQ12

   always_ff @(posedge i_clk) begin
      if (set_wr) set_mem[sel_ff] <= set_wdata;          // RQ6 RQ16
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         nv_cnt_ff <= '0;
      end else if (set_wr) begin
         nv_cnt_ff <= NVW'(P_NV_WRITE_CYCLES);           // RQ7 RQ12
      end else if (nv_busy) begin
         nv_cnt_ff <= nv_cnt_ff - NVW'(1);
      end
   end

   // Wiper and tap select. Reset clears the wiper; recall then refills it.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         recall_ff <= 1'b1;
         wiper_ff  <= wrcl_pkg::WIPER_RESET;             // RQ5
         tap_ff    <= '0;
         dly_ff    <= '0;
      end else if (recall_ff) begin
         recall_ff <= 1'b0;
         wiper_ff  <= set_mem[0];                        // RQ4
         tap_ff    <= tap_decode(set_mem[0]);
      end else if (exec && cmd_ff == wrcl_pkg::CMD_WR_WIPER) begin
         wiper_ff  <= dat_ff;                            // RQ2
         tap_ff    <= tap_decode(dat_ff);                // RQ1
         dly_ff    <= '0;
      end else if (exec && cmd_ff == wrcl_pkg::CMD_TO_WIPER) begin
         wiper_ff  <= set_mem[sel_ff];                   // RQ3
         dly_ff    <= DLW'(P_WIPER_DELAY_CYCLES);        // RQ11
      end else if (dly_ff != '0) begin
         dly_ff    <= dly_ff - DLW'(1);
         if (dly_ff == DLW'(1)) tap_ff <= tap_decode(wiper_ff); // RQ1 RQ11
      end
   end

   // Open-drain data pin: only ever pulls low.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sda_oen <= 1'b1;
         o_nv_busy <= 1'b0;
      end else begin
         o_sda_oen <= ~drive_ff;
         o_nv_busy <= nv_busy;
      end
   end

   assign o_sda_out        = 1'b0;
   assign o_wiper_position = wiper_ff;
   assign o_tap_sel        = tap_ff;
endmodule // wrcl_top

// file: wrcl_monitor.sv
// Concurrent checks on the pins of the wiper register command logic.
// Assumes one core clock domain and a two-wire master far below its rate.
`timescale 1ns/100ps
module wrcl_monitor #(
   parameter int P_NV_WRITE_CYCLES = wrcl_pkg::NV_WRITE_CYCLES
) (
   input wire logic          i_clk,
   input wire logic          i_rstn,
   input wire logic          i_scl,
   input wire logic          i_sda_in,
   input wire logic          o_sda_oen,
   input wire logic [9:0]    o_wiper_position,
   input wire logic [1023:0] o_tap_sel,
   input wire logic          o_nv_busy
);
   logic [31:0] busy_cnt_ff;
   logic [31:0] nxt_busy_cnt;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   // Counts cycles of a retained write so its length can be bounded.
   assign nxt_busy_cnt = o_nv_busy ? busy_cnt_ff + 32'h1 : 32'h0;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_cnt_ff <= 32'h0;
      end else begin
         busy_cnt_ff <= nxt_busy_cnt;
      end
   end
   a_tap_one_hot: assert property (
      $stable(o_wiper_position)[*8] |->
      $onehot(o_tap_sel) && o_tap_sel[o_wiper_position])
      else $error("tap select is not one hot at the wiper position");
   a_busy_bounded: assert property (
      o_nv_busy |-> int'(busy_cnt_ff) < P_NV_WRITE_CYCLES)
      else $error("retained write runs past its maximum time");
   a_busy_full_time: assert property (
      $fell(o_nv_busy) && busy_cnt_ff > 32'h4 |->
      int'(busy_cnt_ff) == P_NV_WRITE_CYCLES)
      else $error("retained write ended early");
   a_busy_no_ack: assert property (
      o_nv_busy && $past(o_nv_busy) |-> o_sda_oen)
      else $error("data line driven during a retained write");
   a_busy_wiper_hold: assert property (
      o_nv_busy && $past(o_nv_busy) |-> $stable(o_wiper_position))
      else $error("wiper changed during a retained write");
   a_sda_scl_low: assert property (
      $changed(o_sda_oen) |-> !i_scl)
      else $error("data line changed while the link clock was high");
   a_wiper_at_stop: assert property (
      $past(i_rstn) && $changed(o_wiper_position) |-> i_scl && i_sda_in)
      else $error("wiper changed outside an idle bus");
   a_tap_follows: assert property (
      $past(i_rstn) && $changed(o_wiper_position) |->
      ##[0:16] o_tap_sel[o_wiper_position])
      else $error("taps did not follow the wiper in time");
endmodule // wrcl_monitor
bind wrcl_top wrcl_monitor #(.P_NV_WRITE_CYCLES(P_NV_WRITE_CYCLES))
   wrcl_monitor_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl),
   .i_sda_in(i_sda_in), .o_sda_oen(o_sda_oen), .o_nv_busy(o_nv_busy),
   .o_wiper_position(o_wiper_position), .o_tap_sel(o_tap_sel));

// file: wrcl_host.sv
// Two-wire bus master model framing bytes at a 160 ns link clock.
// Assumes the bench resolves the open-drain wire with a pull-up.
`timescale 1ns/100ps
module wrcl_host (
   output logic      o_scl,
   output logic      o_sda_pull,
   input  wire logic i_sda
);
   // The link clock stands high whenever no frame is running.
   initial begin
      o_scl = 1'h1;
      o_sda_pull = 1'h0;
   end
   task automatic put_bit(input logic b);
      o_sda_pull = ~b;
      #40 o_scl = 1'h1;
      #80 o_scl = 1'h0;
      #40;
   endtask
   task automatic get_bit(output logic b);
      o_sda_pull = 1'h0;
      #40 o_scl = 1'h1;
      #40 b = i_sda;
      #40 o_scl = 1'h0;
      #40;
   endtask
   task automatic start();
      #40 o_sda_pull = 1'h1;
      #40 o_scl = 1'h0;
      #40;
   endtask
   task automatic stop();
      o_sda_pull = 1'h1;
      #40 o_scl = 1'h1;
      #40 o_sda_pull = 1'h0;
      #80;
   endtask
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      get_bit(b);
      ack = ~b;
   endtask
   task automatic recv_byte(input logic last, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) get_bit(v[i]);
      put_bit(last);
   endtask
endmodule // wrcl_host

// file: tb_wrcl_top.sv
// Self-checking bench for the wiper register command logic.
// Assumes the host model drives the link and the monitor is bound.
`timescale 1ns/100ps
module tb_wrcl_top;
   localparam int NVW = 2000;
   localparam int LIMIT = 60000;
   typedef struct packed {
      logic       rw;
      logic [2:0] op;
      logic [1:0] sel;
      logic [9:0] dat;
   } wrcl_row_s;
   logic          clk, rstn, strap_hi, strap_lo, host_hi, host_lo, ack;
   logic          scl, host_pull, sda_out, sda_oen, nv_busy;
   logic [9:0]    wiper;
   logic [1023:0] tap_sel;
   logic [3:0]    acks;
   logic [15:0]   rd;
   wire           sda;
   int            error_cnt = 0, total_checks = 0, cycles = 0, n;
   wrcl_row_s rows [10] = '{
      '{1'h0, wrcl_pkg::OP_WR_WIPER, 2'h0, 10'h2A5},
      '{1'h1, wrcl_pkg::OP_RD_WIPER, 2'h0, 10'h2A5},
      '{1'h0, wrcl_pkg::OP_WR_SET, 2'h0, 10'h155},
      '{1'h0, wrcl_pkg::OP_WR_SET, 2'h1, 10'h3FF},
      '{1'h0, wrcl_pkg::OP_WR_SET, 2'h3, 10'h0C3},
      '{1'h1, wrcl_pkg::OP_TO_WIPER, 2'h3, 10'h0C3},
      '{1'h0, wrcl_pkg::OP_TO_SET, 2'h2, 10'h0C3},
      '{1'h1, wrcl_pkg::OP_RD_SET, 2'h2, 10'h0C3},
      '{1'h1, wrcl_pkg::OP_RD_SET, 2'h1, 10'h3FF},
      '{1'h1, wrcl_pkg::OP_RD_SET, 2'h0, 10'h155}};
   assign sda = ~host_pull & (sda_oen | sda_out);
   wrcl_top #(.P_NV_WRITE_CYCLES(NVW), .P_WIPER_DELAY_CYCLES(3))
      wrcl_top_inst (
      .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda_in(sda),
      .i_addr_strap_high(strap_hi), .i_addr_strap_low(strap_lo),
      .o_sda_out(sda_out), .o_sda_oen(sda_oen), .o_wiper_position(wiper),
      .o_tap_sel(tap_sel), .o_nv_busy(nv_busy));
   wrcl_host wrcl_host_inst (.o_scl(scl), .o_sda_pull(host_pull), .i_sda(sda));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic check(input string nm, input logic [1023:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s: expected %0h, seen %0h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [7:0] id_byte(input logic rw);
      return {wrcl_pkg::DEVICE_TYPE_DEFAULT, 1'h0, host_hi, host_lo, rw};
   endfunction
   task automatic do_cmd(input logic rw, input logic [7:0] ins,
                         input logic [9:0] wd);
      logic xfer;
      xfer = (ins[7:5] == 3'h6 && rw) || (ins[7:5] == 3'h7 && !rw);
      acks = 4'hF;
      wrcl_host_inst.start();
      wrcl_host_inst.send_byte(id_byte(rw), acks[3]);
      wrcl_host_inst.send_byte(ins, acks[2]);
      if (!xfer && !rw) begin
         wrcl_host_inst.send_byte({6'h3F, wd[9:8]}, acks[1]);
         wrcl_host_inst.send_byte(wd[7:0], acks[0]);
      end
      if (!xfer && rw) begin
         wrcl_host_inst.recv_byte(1'h0, rd[15:8]);
         wrcl_host_inst.recv_byte(1'h1, rd[7:0]);
      end
      wrcl_host_inst.stop();
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic run_row(input wrcl_row_s r);
      do_cmd(r.rw, {r.op, 1'h0, r.sel, 2'h0}, r.dat);
      check("acks", acks, 4'hF);
      if (r.rw && r.op != wrcl_pkg::OP_TO_WIPER)
         check("read", rd, {wrcl_pkg::PAD_FILL, r.dat});
      if ((r.op == wrcl_pkg::OP_WR_WIPER && !r.rw) ||
          (r.op == wrcl_pkg::OP_TO_WIPER && r.rw)) begin
         check("wiper", wiper, r.dat);
         check("tap", tap_sel, 1024'h1 << r.dat);
      end
      for (n = 0; n < NVW + 100 && nv_busy !== 1'h0; n++) @(posedge clk);
      #1;
      check("idle", nv_busy, 1'h0);
      $display("test row %0h ended, %0d mismatches", r, error_cnt);
   endtask
   initial begin
      {rstn, strap_hi, strap_lo, host_hi, host_lo} = 5'h0A;
      repeat (20) @(posedge clk);
      #1 rstn = 1'h1;
      repeat (5) @(posedge clk);
      #1;
      foreach (rows[i]) run_row(rows[i]);
      // A retained write must hold off other traffic until polling acks.
      do_cmd(1'h0, {wrcl_pkg::OP_WR_SET, 5'h04}, 10'h2AA);
      check("busy", nv_busy, 1'h1);
      do_cmd(1'h0, {wrcl_pkg::OP_WR_WIPER, 5'h00}, 10'h001);
      check("busy id", acks[3], 1'h0);
      check("held", wiper, 10'h0C3);
      ack = 1'h0;
      for (n = 0; n < 40 && !ack; n++) begin
         wrcl_host_inst.start();
         wrcl_host_inst.send_byte(id_byte(1'h0), ack);
         wrcl_host_inst.stop();
      end
      check("polled", n > 1 && ack, 1'h1);
      do_cmd(1'h1, {wrcl_pkg::OP_RD_SET, 5'h04}, 10'h000);
      check("set one", rd, {wrcl_pkg::PAD_FILL, 10'h2AA});
      $display("test busy ended, %0d mismatches", error_cnt);
      host_lo = 1'h1;
      do_cmd(1'h0, {wrcl_pkg::OP_WR_WIPER, 5'h00}, 10'h3C0);
      check("strap id", acks[3], 1'h0);
      check("ignored", wiper, 10'h0C3);
      strap_lo = 1'h1;
      repeat (8) @(posedge clk);
      #1;
      do_cmd(1'h0, {wrcl_pkg::OP_WR_WIPER, 5'h00}, 10'h3C0);
      check("strap wiper", wiper, 10'h3C0);
      // A read flag with the wiper-to-setting opcode is no instruction.
      do_cmd(1'h1, {wrcl_pkg::OP_TO_SET, 5'h08}, 10'h000);
      check("bad op", acks, 4'hB);
      check("bad op read", rd, 16'hFFFF);
      check("bad op wiper", wiper, 10'h3C0);
      $display("test strap ended, %0d mismatches", error_cnt);
      rstn = 1'h0;
      repeat (20) @(posedge clk);
      check("in reset", {sda_oen, wiper}, {1'h1, 10'h000});
      check("reset tap", tap_sel, 1024'h0);
      #1 rstn = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      check("recall", wiper, 10'h155);
      check("recall tap", tap_sel, 1024'h1 << 10'h155);
      $display("test recall ended, %0d mismatches", error_cnt);
      end_of_test();
   end
endmodule // tb_wrcl_top
